// ===== logic/sfpi_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - select high: serial data and clock ignored, every lane output floats.
// - after the first select fall, deselected and idle means standby; select low means active.
// - nothing is accepted before the first falling edge of select.
// - command, address and write bits sampled on serial clock rising edges.
// - output data changes only after serial clock falling edges.
// - single mode: lane 0 only in, lane 1 only out.
// - dual and quad: lanes 0 and 1 both carry data both ways.
// - quad: protect pin is lane 2, pause pin is lane 3.
// - protect pin low with method hi=0, lo=1 blocks status writes.
// - same lock refuses changes to guarded array regions while pin low.
// - quad enable set: protect pin is only a data lane.
// - quad enable set: pause function off, pin is a data lane.
// - pause stops serial traffic only, internal work runs on.
// - array split into 4 kbyte sectors from address zero.
// - eight sectors form a half block, two half blocks a block.
// - 4096 sectors, 512 half blocks, 256 blocks fill 24 bits.
// - host uses clock modes 0 or 3 only.
// - quad transfers only accepted with quad enable set.
// - pause enters and leaves only while serial clock is low.
// - paused: output floats, input lane and clock ignored.
module sfpi_top (
	input  wire logic                          i_ref_clk,
	input  wire logic                          i_rst,
	input  wire logic                          i_sclk,
	input  wire logic                          i_cs_n,
	input  wire logic [sfpi_pkg::LANES-1:0]    i_lane_in,
	output logic      [sfpi_pkg::LANES-1:0]    o_lane_out,
	output logic      [sfpi_pkg::LANES-1:0]    o_lane_oe,
	input  wire logic [1:0]                    i_lane_mode,
	input  wire logic                          i_drive_out,
	input  wire logic [sfpi_pkg::BYTE_W-1:0]   i_tx_byte,
	output logic                               o_tx_taken,
	output logic      [sfpi_pkg::BYTE_W-1:0]   o_rx_byte,
	output logic                               o_rx_valid,
	input  wire logic [sfpi_pkg::ADDR_W-1:0]   i_addr,
	output logic      [sfpi_pkg::SECTOR_W-1:0] o_sector,
	output logic      [sfpi_pkg::HALF_W-1:0]   o_half_block,
	output logic      [sfpi_pkg::BLOCK_W-1:0]  o_block,
	input  wire logic                          i_protect_method_hi,
	input  wire logic                          i_protect_method_lo,
	input  wire logic                          i_quad_lane_enable,
	input  wire logic                          i_region_guarded,
	input  wire logic                          i_internal_busy,
	output logic                               o_status_write_block,
	output logic                               o_region_write_block,
	output logic                               o_selected,
	output logic                               o_standby,
	output logic                               o_paused,
	output logic                               o_quad_refused
);
	// ---- reference clock domain ----
	logic [1:0]                  pin_s;
	logic                        cs_s;
	logic                        wp_s;
	logic                        cs_d_ff;
	logic [2:0]                  back_s;
	logic [2:0]                  back_d_ff;
	logic                        cs_fall;
	logic                        rx_evt;
	logic                        tx_evt;
	sfpi_pkg::sfpi_state_t       state_ff;
	sfpi_pkg::sfpi_state_t       nxt_state;
	logic                        armed;
	logic [1:0]                  mode_ff;
	logic                        drive_ff;
	logic                        qe_ff;
	logic                        refused_ff;
	logic                        lock;
	logic                        stat_blk_ff;
	logic                        reg_blk_ff;
	logic [sfpi_pkg::BYTE_W-1:0] tx_hold_ff;
	logic [sfpi_pkg::BYTE_W-1:0] rx_out_ff;
	logic                        rx_valid_ff;
	logic                        tx_taken_ff;

	// ---- serial clock domain ----
	logic [4:0]                  fwd_s;
	logic                        s_rst;
	logic [1:0]                  s_mode;
	logic                        s_drive;
	logic                        s_qe;
	logic [sfpi_pkg::BYTE_W-1:0] rx_sh_ff;
	logic [sfpi_pkg::BYTE_W-1:0] rx_word_ff;
	logic [sfpi_pkg::CNT_W-1:0]  rx_cnt_ff;
	logic                        rx_tgl_ff;
	logic [sfpi_pkg::BYTE_W-1:0] tx_sh_ff;
	logic [sfpi_pkg::LANES-1:0]  tx_out_ff;
	logic [sfpi_pkg::CNT_W-1:0]  tx_cnt_ff;
	logic                        tx_tgl_ff;
	logic                        held_ff;
	logic [sfpi_pkg::CNT_W-1:0]  step;
	logic [sfpi_pkg::CNT_W-1:0]  nxt_rx_cnt;
	logic [sfpi_pkg::BYTE_W-1:0] nxt_rx_sh;
	logic [sfpi_pkg::BYTE_W-1:0] tx_cur;
	logic [sfpi_pkg::LANES-1:0]  nxt_tx_out;
	logic [sfpi_pkg::LANES-1:0]  lane_mask;
	logic                        paused_now;
	logic                        pause_pin;

	// pins from outside the reference domain pass two flops first
	sfpi_sync #(.W(2)) u_pin_sync (
		.i_clk (i_ref_clk),
		.i_d   ({i_lane_in[sfpi_pkg::LANE_WP], i_cs_n}),
		.o_q   (pin_s)
	);
	assign cs_s = pin_s[0];
	assign wp_s = pin_s[1];

	// toggles and pause level coming back from the serial side
	sfpi_sync #(.W(3)) u_back_sync (
		.i_clk (i_ref_clk),
		.i_d   ({paused_now, tx_tgl_ff, rx_tgl_ff}),
		.o_q   (back_s)
	);

	// quasi-static settings going to the serial side
	sfpi_sync #(.W(5)) u_fwd_sync (
		.i_clk (i_sclk),
		.i_d   ({qe_ff, drive_ff, mode_ff, i_rst}),
		.o_q   (fwd_s)
	);
	assign s_rst   = fwd_s[0];
	assign s_mode  = fwd_s[2:1];
	assign s_drive = fwd_s[3];
	assign s_qe    = fwd_s[4];

	sfpi_region u_region (
		.i_clk        (i_ref_clk),
		.i_rst        (i_rst),
		.i_addr       (i_addr),
		.o_sector     (o_sector),
		.o_half_block (o_half_block),
		.o_block      (o_block)
	);

	// edge detection on already synchronised copies; the select history
	// resets low so a pin held low from power-up never reads as a fall
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			cs_d_ff   <= 1'b0;
			back_d_ff <= '0;
		end else begin
			cs_d_ff   <= cs_s;
			back_d_ff <= back_s;
		end
	end
	assign cs_fall = cs_d_ff & ~cs_s;
	assign rx_evt  = back_s[0] ^ back_d_ff[0];
	assign tx_evt  = back_s[1] ^ back_d_ff[1];
	assign armed   = (state_ff != sfpi_pkg::SFPI_POWERUP);

	// select and power tracking
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			sfpi_pkg::SFPI_POWERUP: begin
				if (cs_fall)
					nxt_state = sfpi_pkg::SFPI_ACTIVE;
			end
			sfpi_pkg::SFPI_STANDBY: begin
				if (!cs_s)
					nxt_state = sfpi_pkg::SFPI_ACTIVE;
				else if (i_internal_busy)
					nxt_state = sfpi_pkg::SFPI_BUSY;
			end
			sfpi_pkg::SFPI_ACTIVE: begin
				if (cs_s)
					nxt_state = i_internal_busy ? sfpi_pkg::SFPI_BUSY
					                            : sfpi_pkg::SFPI_STANDBY;
			end
			sfpi_pkg::SFPI_BUSY: begin
				if (!cs_s)
					nxt_state = sfpi_pkg::SFPI_ACTIVE;
				else if (!i_internal_busy)
					nxt_state = sfpi_pkg::SFPI_STANDBY;
			end
			default: nxt_state = sfpi_pkg::SFPI_POWERUP;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			state_ff <= sfpi_pkg::SFPI_POWERUP;
		else
			state_ff <= nxt_state;
	end

	// lane mode: quad falls back to single without quad enable
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			mode_ff    <= sfpi_pkg::SFPI_SINGLE;
			drive_ff   <= 1'b0;
			qe_ff      <= 1'b0;
			refused_ff <= 1'b0;
		end else begin
			drive_ff <= i_drive_out;
			qe_ff    <= i_quad_lane_enable;
			if (i_lane_mode == sfpi_pkg::SFPI_QUAD && !i_quad_lane_enable) begin
				mode_ff    <= sfpi_pkg::SFPI_SINGLE;
				refused_ff <= 1'b1;
			end else begin
				mode_ff    <= i_lane_mode;
				refused_ff <= 1'b0;
			end
		end
	end

	// hardware lock: pin low, method hi=0 lo=1, pin not a data lane
	assign lock = ~wp_s & i_protect_method_lo & ~i_protect_method_hi
	            & ~i_quad_lane_enable;
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			stat_blk_ff <= 1'b0;
			reg_blk_ff  <= 1'b0;
		end else begin
			stat_blk_ff <= lock;
			reg_blk_ff  <= lock & i_region_guarded;
		end
	end

	// byte hand-over: the toggle moves on the same edge as the word and is seen two flops later
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rx_out_ff   <= '0;
			rx_valid_ff <= 1'b0;
			tx_taken_ff <= 1'b0;
			tx_hold_ff  <= '0;
		end else begin
			rx_valid_ff <= rx_evt & armed;
			tx_taken_ff <= tx_evt & armed;
			if (rx_evt && armed)
				rx_out_ff <= rx_word_ff;
			// refill only between uses so the serial side sees a steady word
			if (tx_evt || cs_s)
				tx_hold_ff <= i_tx_byte;
		end
	end

	// bits taken per edge for the current mode
	always_comb begin
		case (s_mode)
			sfpi_pkg::SFPI_DUAL: begin
				step      = 4'h2;
				lane_mask = 4'h3;
			end
			sfpi_pkg::SFPI_QUAD: begin
				step      = 4'h4;
				lane_mask = 4'hf;
			end
			default: begin
				step      = 4'h1;
				lane_mask = 4'h2;
			end
		endcase
	end

	// incoming bits, lane 0 alone in single mode
	always_comb begin
		case (s_mode)
			sfpi_pkg::SFPI_DUAL: nxt_rx_sh = {rx_sh_ff[5:0], i_lane_in[1:0]};
			sfpi_pkg::SFPI_QUAD: nxt_rx_sh = {rx_sh_ff[3:0], i_lane_in};
			default:             nxt_rx_sh = {rx_sh_ff[6:0], i_lane_in[0]};
		endcase
		nxt_rx_cnt = rx_cnt_ff + step;
	end

	// sample on rising edges; deselect or pause freezes the bit counter
	always_ff @(posedge i_sclk) begin
		if (s_rst) begin
			rx_sh_ff   <= '0;
			rx_word_ff <= '0;
			rx_cnt_ff  <= '0;
			rx_tgl_ff  <= 1'b0;
		end else if (!i_cs_n && !pause_pin) begin
			rx_sh_ff <= nxt_rx_sh;
			if (nxt_rx_cnt == 4'(sfpi_pkg::BYTE_W)) begin
				rx_word_ff <= nxt_rx_sh;
				rx_cnt_ff  <= '0;
				rx_tgl_ff  <= ~rx_tgl_ff;
			end else begin
				rx_cnt_ff <= nxt_rx_cnt;
			end
		end
	end

	// next outgoing word, reloaded at each byte boundary
	always_comb begin
		tx_cur = (tx_cnt_ff == '0) ? tx_hold_ff : tx_sh_ff;
		case (s_mode)
			sfpi_pkg::SFPI_DUAL: nxt_tx_out = {2'h0, tx_cur[7:6]};
			sfpi_pkg::SFPI_QUAD: nxt_tx_out = tx_cur[7:4];
			default:             nxt_tx_out = {2'h0, tx_cur[7], 1'b0};
		endcase
	end

	// drive on falling edges so the host samples on the next rise
	always_ff @(negedge i_sclk) begin
		if (s_rst) begin
			tx_sh_ff  <= '0;
			tx_out_ff <= '0;
			tx_cnt_ff <= '0;
			tx_tgl_ff <= 1'b0;
		end else if (s_drive && !i_cs_n && !pause_pin) begin
			tx_out_ff <= nxt_tx_out;
			tx_sh_ff  <= tx_cur << step;
			if (tx_cnt_ff + step == 4'(sfpi_pkg::BYTE_W)) begin
				tx_cnt_ff <= '0;
				tx_tgl_ff <= ~tx_tgl_ff;
			end else begin
				tx_cnt_ff <= tx_cnt_ff + step;
			end
		end
	end

	// pause is latched at falling edges, so it only moves with clock low
	always_ff @(negedge i_sclk) begin
		if (s_rst)
			held_ff <= 1'b0;
		else
			held_ff <= pause_pin;
	end

	// pause level seen by both serial edges; a late latch would let one edge slip
	assign pause_pin = ~s_qe & ~i_lane_in[sfpi_pkg::LANE_PAUSE];

	// with clock low the pin acts at once; with clock high the latched value holds
	assign paused_now = ~s_qe & (i_sclk ? held_ff
	                                    : ~i_lane_in[sfpi_pkg::LANE_PAUSE]);

	// select high floats every lane at once; pause does so at once only while the clock is low
	assign o_lane_oe  = {4{~i_cs_n & s_drive & ~paused_now}} & lane_mask;
	assign o_lane_out = tx_out_ff;

	assign o_tx_taken           = tx_taken_ff;
	assign o_rx_byte            = rx_out_ff;
	assign o_rx_valid           = rx_valid_ff;
	assign o_status_write_block = stat_blk_ff;
	assign o_region_write_block = reg_blk_ff;
	assign o_selected           = (state_ff == sfpi_pkg::SFPI_ACTIVE);
	assign o_standby            = (state_ff == sfpi_pkg::SFPI_STANDBY);
	assign o_paused             = back_s[2];
	assign o_quad_refused       = refused_ff;

	// ---- checks ----
	sequence seq_first_select;
		(state_ff == sfpi_pkg::SFPI_POWERUP) && cs_fall;
	endsequence

	sequence seq_lock_seen;
		lock ##1 lock;
	endsequence

	first_select_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		seq_first_select |=> o_selected)
		else $error("first select edge did not activate");

	no_early_rx_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(state_ff == sfpi_pkg::SFPI_POWERUP) |=> !o_rx_valid)
		else $error("byte delivered before first select edge");

	standby_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(cs_s && !i_internal_busy && state_ff == sfpi_pkg::SFPI_ACTIVE)
		|=> o_standby)
		else $error("idle deselect did not reach standby");

	status_lock_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		seq_lock_seen |-> o_status_write_block)
		else $error("status write not blocked under lock");

	region_lock_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(lock && i_region_guarded) |=> o_region_write_block)
		else $error("guarded region not blocked under lock");

	quad_frees_wp_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_quad_lane_enable |=> !o_status_write_block)
		else $error("protect pin acted with quad enable set");

	quad_refuse_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_lane_mode == sfpi_pkg::SFPI_QUAD && !i_quad_lane_enable)
		|=> (mode_ff == sfpi_pkg::SFPI_SINGLE) && o_quad_refused)
		else $error("quad mode taken without quad enable");

	desel_float_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_cs_n |-> (o_lane_oe == '0))
		else $error("lane driven while deselected");

	pause_freeze_a: assert property (@(posedge i_sclk) disable iff (s_rst)
		pause_pin |=> $stable(rx_cnt_ff) && $stable(rx_sh_ff))
		else $error("input shifted while paused");

	desel_quiet_a: assert property (@(posedge i_sclk) disable iff (s_rst)
		i_cs_n |=> $stable(rx_cnt_ff) && $stable(rx_sh_ff))
		else $error("input shifted while deselected");

	qe_no_pause_a: assert property (@(negedge i_sclk) disable iff (s_rst)
		s_qe |=> !held_ff)
		else $error("pause honoured with quad enable set");

	single_lanes_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(s_mode == sfpi_pkg::SFPI_SINGLE) |-> (o_lane_oe[0] == 1'b0))
		else $error("input lane driven in single mode");

	last_sector_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		(i_addr[sfpi_pkg::ADDR_W-1:sfpi_pkg::SECTOR_LSB] == sfpi_pkg::LAST_SECTOR)
		|=> (&o_block) && (&o_half_block) && (o_sector == sfpi_pkg::LAST_SECTOR))
		else $error("top address not in last sector");
endmodule : sfpi_top

// ===== logic/sfpi_pkg.sv
package sfpi_pkg;
	// byte address layout of the array
	localparam int          ADDR_W      = 24;
	localparam int          SECTOR_LSB  = 12;
	localparam int          HALF_LSB    = 15;
	localparam int          BLOCK_LSB   = 16;
	localparam int          SECTOR_W    = ADDR_W - SECTOR_LSB;
	localparam int          HALF_W      = ADDR_W - HALF_LSB;
	localparam int          BLOCK_W     = ADDR_W - BLOCK_LSB;
	localparam logic [11:0] LAST_SECTOR = 12'hfff;

	// serial word and lane layout
	localparam int          BYTE_W      = 8;
	localparam int          LANES       = 4;
	localparam int          CNT_W       = 4;
	localparam int          LANE_WP     = 2;
	localparam int          LANE_PAUSE  = 3;
	localparam int          SYNC_STAGES = 2;

	// lane modes, gray ordered single -> dual -> quad
	typedef enum logic [1:0] {
		SFPI_SINGLE = 2'h0,
		SFPI_DUAL   = 2'h1,
		SFPI_QUAD   = 2'h3
	} sfpi_mode_t;

	// select and power tracking
	typedef enum logic [1:0] {
		SFPI_POWERUP = 2'h0,
		SFPI_STANDBY = 2'h1,
		SFPI_ACTIVE  = 2'h3,
		SFPI_BUSY    = 2'h2
	} sfpi_state_t;
endpackage : sfpi_pkg

// ===== logic/sfpi_sync.sv
`timescale 1ns/1ps
// two-stage level synchroniser, first stage read only by the second
module sfpi_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// no reset: the chain flushes within two edges
	always_ff @(posedge i_clk) begin
		meta_ff <= i_d;
		sync_ff <= meta_ff;
	end

	assign o_q = sync_ff;
endmodule : sfpi_sync

// ===== logic/sfpi_region.sv
`timescale 1ns/1ps
// splits a byte address into sector, half block and block numbers
module sfpi_region (
	input  wire logic                         i_clk,
	input  wire logic                         i_rst,
	input  wire logic [sfpi_pkg::ADDR_W-1:0]  i_addr,
	output logic      [sfpi_pkg::SECTOR_W-1:0] o_sector,
	output logic      [sfpi_pkg::HALF_W-1:0]   o_half_block,
	output logic      [sfpi_pkg::BLOCK_W-1:0]  o_block
);
	logic [sfpi_pkg::SECTOR_W-1:0] sector_ff;
	logic [sfpi_pkg::HALF_W-1:0]   half_ff;
	logic [sfpi_pkg::BLOCK_W-1:0]  block_ff;

	// plain bit slices, no arithmetic needed
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sector_ff <= '0;
			half_ff   <= '0;
			block_ff  <= '0;
		end else begin
			sector_ff <= i_addr[sfpi_pkg::ADDR_W-1:sfpi_pkg::SECTOR_LSB];
			half_ff   <= i_addr[sfpi_pkg::ADDR_W-1:sfpi_pkg::HALF_LSB];
			block_ff  <= i_addr[sfpi_pkg::ADDR_W-1:sfpi_pkg::BLOCK_LSB];
		end
	end

	assign o_sector     = sector_ff;
	assign o_half_block = half_ff;
	assign o_block      = block_ff;
endmodule : sfpi_region

// ===== tb/sfpi_host_model.sv
`timescale 1ns/1ps
// host side of the serial link, clock rests low between frames unless idle pulses are asked for
module sfpi_host_model (
	input  wire logic [3:0] i_pin,
	output logic            o_sclk,
	output logic            o_cs_n,
	output logic [3:0]      o_lane
);
	logic [3:0] drv_ff;
	logic [3:0] oe_ff;

	// released lanes: 2 and 3 pulled up, 0 and 1 show the inverse of the last value
	assign o_lane = (oe_ff & drv_ff) | (~oe_ff & {2'b11, ~drv_ff[1:0]});

	// select held low from power-up so no falling edge is seen yet
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b0;
		drv_ff = 4'h0;
		oe_ff  = 4'h0;
	end

	// mode 0 pulses, data is only ever changed while the clock is low
	task automatic clocks(input int n);
		repeat (n) begin
			#40 o_sclk = 1'b1;
			#40 o_sclk = 1'b0;
		end
	endtask : clocks

	task automatic set_lane(input int k, input logic v);
		oe_ff[k]  = 1'b1;
		drv_ff[k] = v;
	endtask : set_lane

	task automatic select();
		#40 o_cs_n = 1'b0;
	endtask : select

	// one whole byte, msb first, w lanes per rising edge
	task automatic send(input int w, input logic [7:0] b);
		logic [7:0] sh;
		sh = b;
		if (o_cs_n)
			select();
		repeat (8 / w) begin
			for (int k = 0; k < w; k++) begin
				oe_ff[k]  = 1'b1;
				drv_ff[k] = sh[8 - w + k];
			end
			sh = sh << w;
			clocks(1);
		end
		#40 o_cs_n = 1'b1;
		oe_ff = 4'h0;
	endtask : send

	// mode 3 read: first falling edge brings the first bit, sampled on the rise
	task automatic read(output logic [7:0] got);
		got = 8'h00;
		oe_ff = 4'h0;
		#40 o_sclk = 1'b1;
		select();
		repeat (8) begin
			#40 o_sclk = 1'b0;
			#40 o_sclk = 1'b1;
			got = {got[6:0], i_pin[1]};
		end
		#40 o_cs_n = 1'b1;
		#40 o_sclk = 1'b0;
	endtask : read
endmodule : sfpi_host_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps
// pin front end against the host model, byte and level checks
module tb_top;
	logic        ref_clk, rst, sclk, cs_n, drive_out, tx_taken, rx_valid;
	logic [3:0]  host_lane, pin, lane_out, lane_oe;
	logic [1:0]  lane_mode;
	logic [7:0]  tx_byte, rx_byte, block;
	logic [23:0] addr;
	logic [11:0] sector;
	logic [8:0]  half_block;
	logic        method_hi, method_lo, qe, guarded, busy, st_block, rg_block;
	logic        selected, standby, paused, quad_refused;
	int          bad_count, samples_checked;

	// wire level: device drive wins where enabled, else the host side
	assign pin = (lane_oe & lane_out) | (~lane_oe & host_lane);

	sfpi_top sfpi_top_i (
		.i_ref_clk(ref_clk), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n),
		.i_lane_in(pin), .o_lane_out(lane_out), .o_lane_oe(lane_oe),
		.i_lane_mode(lane_mode), .i_drive_out(drive_out), .i_tx_byte(tx_byte),
		.o_tx_taken(tx_taken), .o_rx_byte(rx_byte), .o_rx_valid(rx_valid),
		.i_addr(addr), .o_sector(sector), .o_half_block(half_block), .o_block(block),
		.i_protect_method_hi(method_hi), .i_protect_method_lo(method_lo),
		.i_quad_lane_enable(qe), .i_region_guarded(guarded), .i_internal_busy(busy),
		.o_status_write_block(st_block), .o_region_write_block(rg_block),
		.o_selected(selected), .o_standby(standby), .o_paused(paused),
		.o_quad_refused(quad_refused)
	);

	sfpi_host_model sfpi_host_model_i (
		.i_pin(pin), .o_sclk(sclk), .o_cs_n(cs_n), .o_lane(host_lane)
	);

	// reference clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("wrong value %s expected %0h seen %0h", name, exp, seen);
			bad_count++;
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc

	// bounded wait for the received-byte pulse, then spacing for the hand-over
	task automatic wait_rx(input logic [7:0] exp);
		int n;
		n = 0;
		do begin
			cyc(1);
			n++;
			if (n > 30) begin
				bad_count++;
				end_of_test();
			end
		end while (rx_valid !== 1'b1);
		check("rx_byte", 32'(rx_byte), 32'(exp));
		cyc(5);
	endtask : wait_rx

	// bytes before the first select fall are dropped, then power states
	task automatic t_powerup();
		int n;
		n = 0;
		sfpi_host_model_i.send(1, 8'h81);
		repeat (10) begin
			cyc(1);
			n += int'(rx_valid === 1'b1);
		end
		check("early rx", 32'(n), 32'd0);
		check("lane oe", 32'(lane_oe), 32'd0);
		sfpi_host_model_i.select();
		cyc(4);
		check("selected", 32'(selected), 32'd1);
		busy = 1'b1;
		sfpi_host_model_i.send(1, 8'ha5);
		wait_rx(8'ha5);
		check("standby busy", 32'(standby), 32'd0);
		busy = 1'b0;
		cyc(5);
		check("standby", 32'(standby), 32'd1);
	endtask : t_powerup

	task automatic t_read();
		logic [7:0] got;
		int         n;
		drive_out = 1'b1;
		tx_byte = 8'h3c;
		cyc(3);
		// idle pulses with select high carry the drive setting across
		sfpi_host_model_i.clocks(3);
		sfpi_host_model_i.read(got);
		check("read byte", 32'(got), 32'h3c);
		n = 0;
		repeat (8) begin
			cyc(1);
			n += int'(tx_taken === 1'b1);
		end
		check("tx taken", 32'(n), 32'd1);
		drive_out = 1'b0;
	endtask : t_read

	// dual then quad, quad first refused without the enable
	task automatic t_multi();
		lane_mode = sfpi_pkg::SFPI_DUAL;
		sfpi_host_model_i.clocks(4);
		sfpi_host_model_i.send(2, 8'h96);
		wait_rx(8'h96);
		qe = 1'b0;
		lane_mode = sfpi_pkg::SFPI_QUAD;
		cyc(5);
		check("quad refused", 32'(quad_refused), 32'd1);
		qe = 1'b1;
		cyc(5);
		check("quad allowed", 32'(quad_refused), 32'd0);
		sfpi_host_model_i.clocks(4);
		sfpi_host_model_i.send(4, 8'hc7);
		wait_rx(8'hc7);
		lane_mode = sfpi_pkg::SFPI_SINGLE;
		sfpi_host_model_i.clocks(4);
	endtask : t_multi

	// every method pair with and without quad enable and region guard
	task automatic t_protect();
		logic lock;
		cyc(1);
		for (int m = 0; m < 16; m++) begin
			method_hi = m[1];
			method_lo = m[0];
			qe = m[2];
			guarded = m[3];
			lock = (m[2:0] == 1);
			sfpi_host_model_i.set_lane(2, 1'b0);
			cyc(5);
			check("status lock", 32'(st_block), 32'(lock));
			check("region lock", 32'(rg_block), 32'(lock & m[3]));
			sfpi_host_model_i.set_lane(2, 1'b1);
			cyc(5);
			check("status free", 32'(st_block), 32'd0);
		end
	endtask : t_protect

	// pause floats outputs and swallows clocks; with quad enable it is ignored
	task automatic t_pause();
		qe = 1'b0;
		drive_out = 1'b1;
		cyc(2);
		// settings reach the link side only on serial edges
		sfpi_host_model_i.clocks(4);
		sfpi_host_model_i.select();
		sfpi_host_model_i.set_lane(3, 1'b0);
		cyc(5);
		check("paused", 32'(paused), 32'd1);
		check("oe paused", 32'(lane_oe), 32'd0);
		sfpi_host_model_i.set_lane(0, 1'b1);
		sfpi_host_model_i.clocks(3);
		sfpi_host_model_i.set_lane(3, 1'b1);
		cyc(5);
		check("resumed", 32'(paused), 32'd0);
		check("oe resumed", 32'(lane_oe), 32'h2);
		drive_out = 1'b0;
		sfpi_host_model_i.send(1, 8'h5a);
		wait_rx(8'h5a);
		qe = 1'b1;
		sfpi_host_model_i.clocks(4);
		sfpi_host_model_i.select();
		sfpi_host_model_i.set_lane(3, 1'b0);
		cyc(5);
		check("no pause", 32'(paused), 32'd0);
		sfpi_host_model_i.send(1, 8'h3e);
		wait_rx(8'h3e);
	endtask : t_pause

	// region numbers from 4k, 32k and 64k sizes at range edges
	task automatic t_region();
		logic [23:0] tbl [7];
		tbl = '{24'h000000, 24'h000fff, 24'h007000, 24'h007fff, 24'h008000,
			24'hfff000, 24'hffffff};
		foreach (tbl[k]) begin
			addr = tbl[k];
			cyc(2);
			check("sector", 32'(sector), 32'(tbl[k] >> 12));
			check("half block", 32'(half_block), 32'(tbl[k] >> 15));
			check("block", 32'(block), 32'(tbl[k] >> 16));
		end
	endtask : t_region

	// main sequence; serial clock must run during reset
	initial begin
		rst = 1'b1;
		{lane_mode, drive_out, tx_byte, addr} = '0;
		{method_hi, method_lo, qe, guarded, busy} = '0;
		bad_count = 0;
		samples_checked = 0;
		// serial edges straddle the release so the link side resets too
		fork
			begin
				#1;
				cyc(2);
				rst = 1'b0;
			end
			begin
				#10;
				sfpi_host_model_i.clocks(4);
			end
		join
		t_powerup();
		t_read();
		t_multi();
		t_protect();
		t_pause();
		t_region();
		end_of_test();
	end

	// hang guard
	initial begin
		#2000000;
		bad_count++;
		end_of_test();
	end
endmodule : tb_top
